// ### hw/cmp_out_pkg.sv
package cmp_out_pkg;

  // ==========================================================================
  // Register map (word offsets on the plain port)
  // ==========================================================================
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_COUNT   = 4'h1;
  localparam logic [3:0] ADDR_CMPVAL  = 4'h2;
  localparam logic [3:0] ADDR_STATUS  = 4'h3;
  localparam logic [3:0] ADDR_PORT    = 4'h4;

  // ==========================================================================
  // Control, status and port field positions
  // ==========================================================================
  localparam int CTRL_WAVE_LSB   = 0;
  localparam int CTRL_ACTION_LSB = 2;
  localparam int CTRL_FORCE_BIT  = 4;
  localparam int CTRL_RUN_BIT    = 5;
  localparam int STAT_OVF_BIT    = 0;
  localparam int STAT_CMF_BIT    = 1;
  localparam int STAT_STATE_BIT  = 2;
  localparam int PORT_VAL_BIT    = 0;
  localparam int PORT_DIR_BIT    = 1;

  // ==========================================================================
  // Reset values and counts
  // ==========================================================================
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  localparam logic [7:0] COUNT_ZERO  = 8'h00;
  localparam logic [7:0] CMPVAL_RST  = 8'h00;
  localparam logic [1:0] RST_FIELD   = 2'h0;

  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'b00,
    WAVE_PCPWM  = 2'b01,
    WAVE_CTC    = 2'b10,
    WAVE_FPWM   = 2'b11
  } wave_mode_e;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } out_action_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

endpackage

// ### hw/compare_output_pin_and_normal_count.sv
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module compare_output_pin_and_normal_count (
  // Clock, reset, enable
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_clk_en,
  // Register port
  input  wire cmp_out_pkg::bus_req_s i_bus,
  output logic [7:0]                 o_rdata,
  // Interrupt service acknowledges
  input  wire logic                  i_ovf_ack,
  input  wire logic                  i_cmf_ack,
  // Compare pin
  input  wire logic                  i_pin,
  output logic                       o_pin_out,
  output logic                       o_pin_oe,
  // Flags
  output logic                       o_overflow_flag,
  output logic                       o_compare_match_flag
);
  import cmp_out_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0] waveform_mode_field;
    logic [1:0] output_action_field;
    logic       run;
    logic [7:0] counter_value;
    logic [7:0] compare_value;
    logic       up;
    logic       overflow_flag;
    logic       compare_match_flag;
    logic       match_d;
    logic       block;
    logic       compare_output_state;
    logic       port_val;
    logic       compare_pin_direction_bit;
    logic [2:0] pin_sync;
    logic       pin_level;
    logic [7:0] rdata;
    logic       pin_out;
    logic       pin_oe;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  function automatic logic is_pwm(input logic [1:0] wm);
    is_pwm = (wm == WAVE_FPWM) || (wm == WAVE_PCPWM);
  endfunction

  function automatic logic apply_act(input logic [1:0] act, input logic cur);
    case (act)
      ACT_TOGGLE: apply_act = ~cur;
      ACT_CLEAR:  apply_act = 1'b0;
      ACT_SET:    apply_act = 1'b1;
      default:    apply_act = cur;
    endcase
  endfunction

  logic wr_ctrl;
  logic wr_count;
  logic force_hit;
  logic match_now;
  logic ovf_evt;
  logic [7:0] rd_mux;

  assign wr_ctrl   = i_bus.wr && (i_bus.addr == ADDR_CTRL);
  assign wr_count  = i_bus.wr && (i_bus.addr == ADDR_COUNT);
  assign force_hit = wr_ctrl && i_bus.wdata[CTRL_FORCE_BIT]
                     && !is_pwm(i_bus.wdata[CTRL_WAVE_LSB +: 2]);
  assign match_now = (st_r.counter_value == st_r.compare_value) && !st_r.block;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_nxt  = st_r;
    ovf_evt = 1'b0;
    rd_mux  = 8'h00;

    // Pin input, three stages; level moves once the last two agree
    st_nxt.pin_sync = {st_r.pin_sync[1:0], i_pin};
    if (st_r.pin_sync[2] == st_r.pin_sync[1]) begin
      st_nxt.pin_level = st_r.pin_sync[2];
    end

    // Counting follows only the waveform mode; action field not consulted
    if (st_r.run) begin
      case (st_r.waveform_mode_field)
        WAVE_NORMAL: begin
          st_nxt.counter_value = st_r.counter_value + 8'h01;
          ovf_evt = (st_r.counter_value == COUNT_MAX);
        end
        WAVE_CTC: begin
          if (match_now) begin
            st_nxt.counter_value = COUNT_ZERO;
          end else begin
            st_nxt.counter_value = st_r.counter_value + 8'h01;
          end
          ovf_evt = (st_r.counter_value == COUNT_MAX);
        end
        WAVE_FPWM: begin
          st_nxt.counter_value = st_r.counter_value + 8'h01;
          ovf_evt = (st_r.counter_value == COUNT_MAX);
        end
        WAVE_PCPWM: begin
          if (st_r.up) begin
            st_nxt.counter_value = st_r.counter_value + 8'h01;
            if (st_r.counter_value == (COUNT_MAX - 8'h01)) begin
              st_nxt.up = 1'b0;
            end
          end else begin
            st_nxt.counter_value = st_r.counter_value - 8'h01;
            if (st_r.counter_value == (COUNT_ZERO + 8'h01)) begin
              st_nxt.up = 1'b1;
              ovf_evt   = 1'b1;
            end
          end
        end
        default: st_nxt.counter_value = st_r.counter_value;
      endcase
      st_nxt.block = 1'b0;

      // Compare state update on a real match, using the action now held
      if (match_now) begin
        if (!is_pwm(st_r.waveform_mode_field)) begin
          st_nxt.compare_output_state =
            apply_act(st_r.output_action_field, st_r.compare_output_state);
        end else if (st_r.output_action_field[1]) begin
          // Bit 0 selects inverted polarity
          if (st_r.waveform_mode_field == WAVE_FPWM || st_r.up) begin
            st_nxt.compare_output_state = st_r.output_action_field[0];
          end else begin
            st_nxt.compare_output_state = ~st_r.output_action_field[0];
          end
        end
      end
      if (st_r.waveform_mode_field == WAVE_FPWM && st_r.output_action_field[1]
          && st_r.counter_value == COUNT_MAX) begin
        st_nxt.compare_output_state = ~st_r.output_action_field[0];
      end
    end
    st_nxt.match_d = st_r.run && match_now;

    // Flags: hardware set wins over the acknowledge
    if (i_ovf_ack) begin
      st_nxt.overflow_flag = 1'b0;
    end
    if (ovf_evt) begin
      st_nxt.overflow_flag = 1'b1;
    end
    if (i_cmf_ack) begin
      st_nxt.compare_match_flag = 1'b0;
    end
    if (st_r.match_d) begin
      st_nxt.compare_match_flag = 1'b1;
    end

    // Register writes
    if (wr_ctrl) begin
      st_nxt.waveform_mode_field = i_bus.wdata[CTRL_WAVE_LSB +: 2];
      st_nxt.output_action_field = i_bus.wdata[CTRL_ACTION_LSB +: 2];
      st_nxt.run                 = i_bus.wdata[CTRL_RUN_BIT];
      if (force_hit) begin
        // Forced match touches only the compare state
        st_nxt.compare_output_state = apply_act(i_bus.wdata[CTRL_ACTION_LSB +: 2],
                                                st_r.compare_output_state);
      end
    end
    if (wr_count) begin
      st_nxt.counter_value = i_bus.wdata;
      st_nxt.block         = 1'b1;
    end
    if (i_bus.wr && i_bus.addr == ADDR_CMPVAL) begin
      st_nxt.compare_value = i_bus.wdata;
    end
    if (i_bus.wr && i_bus.addr == ADDR_PORT) begin
      st_nxt.port_val                  = i_bus.wdata[PORT_VAL_BIT];
      st_nxt.compare_pin_direction_bit = i_bus.wdata[PORT_DIR_BIT];
    end

    // Read data
    case (i_bus.addr)
      ADDR_CTRL: begin
        rd_mux[CTRL_WAVE_LSB +: 2]   = st_r.waveform_mode_field;
        rd_mux[CTRL_ACTION_LSB +: 2] = st_r.output_action_field;
        rd_mux[CTRL_RUN_BIT]         = st_r.run;
      end
      ADDR_COUNT:  rd_mux = st_r.counter_value;
      ADDR_CMPVAL: rd_mux = st_r.compare_value;
      ADDR_STATUS: begin
        rd_mux[STAT_OVF_BIT]   = st_r.overflow_flag;
        rd_mux[STAT_CMF_BIT]   = st_r.compare_match_flag;
        rd_mux[STAT_STATE_BIT] = st_r.compare_output_state;
      end
      ADDR_PORT: begin
        rd_mux[PORT_VAL_BIT] = st_r.pin_level;
        rd_mux[PORT_DIR_BIT] = st_r.compare_pin_direction_bit;
      end
      default: rd_mux = 8'h00;
    endcase
    st_nxt.rdata = i_bus.rd ? rd_mux : 8'h00;

    // Pin override, independent of waveform mode
    st_nxt.pin_out = (st_nxt.output_action_field != ACT_NONE)
                     ? st_nxt.compare_output_state : st_nxt.port_val;
    st_nxt.pin_oe  = st_nxt.compare_pin_direction_bit;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
      st_r.compare_value <= CMPVAL_RST;
      st_r.up            <= 1'b1;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata              = st_r.rdata;
  assign o_pin_out            = st_r.pin_out;
  assign o_pin_oe             = st_r.pin_oe;
  assign o_overflow_flag      = st_r.overflow_flag;
  assign o_compare_match_flag = st_r.compare_match_flag;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_wrap;
    st_r.run && i_clk_en && st_r.waveform_mode_field == WAVE_NORMAL
      && st_r.counter_value == COUNT_MAX && !wr_count;
  endsequence

  property p_wrap;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      s_wrap |=> (st_r.counter_value == COUNT_ZERO) && st_r.overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("No wrap to zero with overflow");

  property p_inc;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_r.run && i_clk_en && st_r.waveform_mode_field == WAVE_NORMAL && !wr_count)
      |=> st_r.counter_value == $past(st_r.counter_value) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("Normal mode did not increment");

  property p_ovf_sticky;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_r.overflow_flag && !i_ovf_ack) |=> st_r.overflow_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("Overflow flag lost");

  property p_ovf_ack;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_clk_en && i_ovf_ack && !ovf_evt) |=> !st_r.overflow_flag;
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) else $error("Overflow flag not cleared");

  property p_override;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_r.output_action_field != ACT_NONE) |-> (o_pin_out == st_r.compare_output_state);
  endproperty
  a_override: assert property (p_override) else $error("Pin not overridden");

  property p_hold;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_clk_en && st_r.output_action_field == ACT_NONE && !wr_ctrl)
      |=> $stable(st_r.compare_output_state);
  endproperty
  a_hold: assert property (p_hold) else $error("State changed with no action");

  property p_force;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_clk_en && force_hit && i_bus.wdata[CTRL_ACTION_LSB +: 2] == ACT_SET)
      |=> st_r.compare_output_state && ($stable(st_r.compare_match_flag)
          || $past(st_r.match_d) || $past(i_cmf_ack));
  endproperty
  a_force: assert property (p_force) else $error("Force did not set state");

  property p_force_pwm;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_clk_en && wr_ctrl && !st_r.run && is_pwm(i_bus.wdata[CTRL_WAVE_LSB +: 2]))
      |=> $stable(st_r.compare_output_state);
  endproperty
  a_force_pwm: assert property (p_force_pwm) else $error("Force acted in PWM");

  property p_dir;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      ##1 (o_pin_oe == st_r.compare_pin_direction_bit);
  endproperty
  a_dir: assert property (p_dir) else $error("Pin enable differs from direction");

  // ==========================================================================
  // Compare, force, pin source, overflow and enable checks
  // ==========================================================================
  sequence s_normal_match;
    i_clk_en && st_r.run && match_now && !wr_ctrl
      && st_r.waveform_mode_field == WAVE_NORMAL;
  endsequence

  property p_toggle;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (s_normal_match ##0 (st_r.output_action_field == ACT_TOGGLE))
      |=> st_r.compare_output_state != $past(st_r.compare_output_state);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Match did not toggle state");

  property p_port_src;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_r.output_action_field == ACT_NONE) |-> (o_pin_out == st_r.port_val);
  endproperty
  a_port_src: assert property (p_port_src) else $error("Pin not from port value");

  // Stopped counter so only the force itself could move the count
  property p_force_count;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_clk_en && force_hit && !st_r.run) |=> $stable(st_r.counter_value);
  endproperty
  a_force_count: assert property (p_force_count) else $error("Force moved counter");

  property p_force_flag;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_clk_en && force_hit && !st_r.match_d) |=> !$rose(o_compare_match_flag);
  endproperty
  a_force_flag: assert property (p_force_flag) else $error("Force set match flag");

  property p_ovf_only_wrap;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_clk_en && st_r.waveform_mode_field == WAVE_NORMAL
        && !(st_r.run && st_r.counter_value == COUNT_MAX)) |=> !$rose(o_overflow_flag);
  endproperty
  a_ovf_only_wrap: assert property (p_ovf_only_wrap) else $error("Stray overflow");

  property p_freeze;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      !i_clk_en |=> $stable(st_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved with enable low");

endmodule

`default_nettype wire

// ### testbench/test_compare_output_pin_and_normal_count.sv
`timescale 1ns/1ps
`default_nettype none

module test_compare_output_pin_and_normal_count;
  import cmp_out_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic       clk;
  logic       rst;
  logic       clk_en;
  bus_req_s   bus;
  logic [7:0] rdata;
  logic       ovf_ack;
  logic       cmf_ack;
  logic       pin_in;
  logic       pin_out;
  logic       pin_oe;
  logic       ovf;
  logic       cmf;
  int         err_total;
  int         checked;
  logic [7:0] q;
  int         n;
  logic [1:0] act [7] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3, 2'h0};
  logic       st  [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  compare_output_pin_and_normal_count dut (
    .i_clk_sys            (clk),
    .i_sys_rst            (rst),
    .i_clk_en             (clk_en),
    .i_bus                (bus),
    .o_rdata              (rdata),
    .i_ovf_ack            (ovf_ack),
    .i_cmf_ack            (cmf_ack),
    .i_pin                (pin_in),
    .o_pin_out            (pin_out),
    .o_pin_oe             (pin_oe),
    .o_overflow_flag      (ovf),
    .o_compare_match_flag (cmf)
  );

  // ==========================================================================
  // Clock
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
    // Idle edge so a following write never re-raises the strobe in this step
    @(posedge clk);
  endtask

  // Data stands only in the cycle after the strobe; sampled mid-cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  // Pin and flags are registered; give them two edges to land
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole sequence takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    err_total = 0;
    checked   = 0;
    rst       = 1'b1;
    clk_en    = 1'b1;
    bus       = '0;
    ovf_ack   = 1'b0;
    cmf_ack   = 1'b0;
    pin_in    = 1'b0;
    repeat (10) @(posedge clk);
    chk({5'h0, pin_oe, ovf, cmf}, 8'h00);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTRL, q);   chk(q, 8'h00);
    rd(ADDR_COUNT, q);  chk(q, 8'h00);
    rd(ADDR_CMPVAL, q); chk(q, 8'h00);
    rd(4'h7, q);        chk(q, 8'h00);
    wr(ADDR_CMPVAL, 8'h80);
    wr(ADDR_COUNT, 8'h10);
    cmf_ack <= 1'b1;
    @(posedge clk);
    cmf_ack <= 1'b0;
    // Forced actions with a stopped counter
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_CTRL, {3'h0, 1'b1, act[i], 2'h0});
      rd(ADDR_STATUS, q);
      chk(q, {5'h0, st[i], 2'b00});
    end
    rd(ADDR_COUNT, q); chk(q, 8'h10);
    wr(ADDR_CTRL, 8'h1B);
    rd(ADDR_STATUS, q); chk(q, 8'h04);
    wr(ADDR_CTRL, 8'h19);
    rd(ADDR_STATUS, q); chk(q, 8'h04);
    // Pin source and direction
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_PORT, 8'h01);
    settle(); chk({pin_oe, pin_out}, 8'h01);
    @(posedge clk);
    wr(ADDR_PORT, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    settle(); chk({pin_oe, pin_out}, 8'h01);
    @(posedge clk);
    wr(ADDR_PORT, 8'h02);
    settle(); chk({pin_oe, pin_out}, 8'h03);
    for (int w = 0; w < 4; w++) begin
      @(posedge clk);
      wr(ADDR_CTRL, {4'h0, 2'h2, w[1:0]});
      settle(); chk({pin_oe, pin_out}, 8'h03);
    end
    @(posedge clk);
    wr(ADDR_CTRL, 8'h00);
    settle(); chk({pin_oe, pin_out}, 8'h02);
    pin_in <= 1'b1;
    repeat (5) @(posedge clk);
    rd(ADDR_PORT, q); chk(q, 8'h03);
    // Match takes effect only after the new field is written
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CMPVAL, 8'h30);
    wr(ADDR_COUNT, 8'h2C);
    wr(ADDR_CTRL, 8'h24);
    rd(ADDR_STATUS, q); chk(q, 8'h00);
    repeat (8) @(posedge clk);
    rd(ADDR_STATUS, q); chk(q, 8'h06);
    wr(ADDR_CTRL, 8'h04);
    cmf_ack <= 1'b1;
    @(posedge clk);
    cmf_ack <= 1'b0;
    rd(ADDR_STATUS, q); chk(q, 8'h04);
    // Wrap and overflow timing, action field must not alter counting
    wr(ADDR_COUNT, 8'hFC);
    wr(ADDR_CTRL, 8'h2C);
    n = 0;
    for (int i = 1; i <= 8 && n == 0; i++) begin
      @(posedge clk);
      @(negedge clk);
      if (ovf === 1'b1) n = i;
    end
    chk(n[7:0], 8'h03);
    @(posedge clk);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({7'h0, ovf}, 8'h01);
    @(posedge clk);
    wr(ADDR_COUNT, 8'h40);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_COUNT, q); chk(q, 8'h42);
    ovf_ack <= 1'b1;
    @(posedge clk);
    ovf_ack <= 1'b0;
    settle(); chk({7'h0, ovf}, 8'h00);
    // Enable low for ten edges: the running count must not move
    wr(ADDR_CTRL, 8'h20);
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    clk_en <= 1'b1;
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_COUNT, q); chk(q, 8'h44);
    complete_run();
  end

endmodule

`default_nettype wire
